// ==== include/cmpsel_params.svh ====
// Purpose: Constants for the comparator1 input select register
// Assumes: Single core clock, synchronous active-high reset
// Notes:   Offsets, field positions, reset value and reserved-code masks
`ifndef CMPSEL_PARAMS_SVH
`define CMPSEL_PARAMS_SVH

// Register location in the special function register space
`define CMPSEL_REG_PAGE    8'h00
`define CMPSEL_REG_ADDR    8'h9e

// Reset value and field layout
`define CMPSEL_REG_RESET   8'hff
`define CMPSEL_NEG_MSB     7
`define CMPSEL_NEG_LSB     4
`define CMPSEL_POS_MSB     3
`define CMPSEL_POS_LSB     0

// Reserved codes: negative 0100, 0101, 1011; positive 0100..0110
`define CMPSEL_NEG_RSVD    16'h0830
`define CMPSEL_POS_RSVD    16'h0070

// Internal source codes shared by both fields
`define CMPSEL_CODE_TOUCH  4'hc
`define CMPSEL_CODE_HALF   4'hd
`define CMPSEL_CODE_SUPPLY 4'he
`define CMPSEL_CODE_TOP    4'hf

`endif

// ==== include/cmpsel_pkg.sv ====
// Purpose: Types for the comparator1 input select block
// Assumes: Constants come from cmpsel_params.svh
// Notes:   One select line per field code
package cmpsel_pkg;

    // A four-bit input selection code
    typedef logic [3:0] cmpsel_code_t;

    // One-hot switch enables, indexed by code
    typedef logic [15:0] cmpsel_sel_t;

    // Register byte
    typedef logic [7:0] cmpsel_byte_t;

    // Codes that pick internal sources rather than port pins
    typedef enum logic [3:0] {
        CMPSEL_SRC_TOUCH  = 4'b1100,
        CMPSEL_SRC_HALF   = 4'b1101,
        CMPSEL_SRC_SUPPLY = 4'b1110,
        CMPSEL_SRC_TOP    = 4'b1111
    } cmpsel_src_t;

endpackage

// ==== design/cmpsel_decode.sv ====
// Purpose: Decode one selection field into one-hot switch enables
// Assumes: Purely combinational, code is the register's next value
// Notes:   Reserved codes are masked so the input floats
`timescale 1ns/1ps
module cmpsel_decode #(
    parameter logic [15:0] RSVD_MASK = 16'h0000
) (
    // Field code
    input  wire cmpsel_pkg::cmpsel_code_t code,
    // Switch enables
    output cmpsel_pkg::cmpsel_sel_t       sel
);

    // One comparator per code; masked codes never close a switch
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_line
            // Cast keeps the compare at the code width; a genvar takes no part-select
            assign sel[i] = (code == 4'(i)) && !RSVD_MASK[i];
        end
    endgenerate

endmodule

// ==== design/cmpsel_top.sv ====
// Purpose: Comparator1 input select register and switch decode
// Assumes: SFR strobes synchronous to core_clk, one access per strobe
// Notes:   Select lines follow the register in the same cycle it updates
`timescale 1ns/1ps
`include "cmpsel_params.svh"
module cmpsel_top #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    // Special function register access
    input  wire logic [7:0]                sfr_page,
    input  wire logic [ADDR_W-1:0]         sfr_addr,
    input  wire logic                      sfr_wr,
    input  wire logic                      sfr_rd,
    input  wire cmpsel_pkg::cmpsel_byte_t  sfr_wdata,
    output cmpsel_pkg::cmpsel_byte_t       sfr_rdata,
    output logic                           sfr_rdata_valid,
    // Stored register and switch enables
    output cmpsel_pkg::cmpsel_byte_t       comparator1_input_select,
    output cmpsel_pkg::cmpsel_sel_t        neg_sel,
    output cmpsel_pkg::cmpsel_sel_t        pos_sel
);

    // Only an 8-bit register over an 8-bit SFR address makes sense here
    if (DATA_W != 8 || ADDR_W != 8) begin : g_bad_param
        $error("cmpsel_top supports only ADDR_W = 8 and DATA_W = 8");
    end

    cmpsel_pkg::cmpsel_byte_t  next_comparator1_input_select;
    cmpsel_pkg::cmpsel_byte_t  next_sfr_rdata;
    logic                      next_sfr_rdata_valid;
    cmpsel_pkg::cmpsel_sel_t   next_neg_sel;
    cmpsel_pkg::cmpsel_sel_t   next_pos_sel;
    cmpsel_pkg::cmpsel_code_t  next_neg_code;
    cmpsel_pkg::cmpsel_code_t  next_pos_code;
    logic                      hit;

    // Address decode: page and address must both match
    assign hit = (sfr_page == `CMPSEL_REG_PAGE) && (sfr_addr == `CMPSEL_REG_ADDR);

    // Register next value; every bit writable
    always_comb begin
        next_comparator1_input_select = comparator1_input_select;
        if (sfr_wr && hit) begin
            next_comparator1_input_select = sfr_wdata;
        end
    end

    // Read path answers one cycle later with the value before any write
    always_comb begin
        next_sfr_rdata       = sfr_rdata;
        next_sfr_rdata_valid = 1'b0;
        if (sfr_rd && hit) begin
            next_sfr_rdata       = comparator1_input_select;
            next_sfr_rdata_valid = 1'b1;
        end
    end

    // Decode from the next value so switches track the register without lag
    assign next_neg_code = next_comparator1_input_select[`CMPSEL_NEG_MSB:`CMPSEL_NEG_LSB];
    assign next_pos_code = next_comparator1_input_select[`CMPSEL_POS_MSB:`CMPSEL_POS_LSB];

    cmpsel_decode #(
        .RSVD_MASK (`CMPSEL_NEG_RSVD)
    ) u_neg_decode (
        .code (next_neg_code),
        .sel  (next_neg_sel)
    );

    cmpsel_decode #(
        .RSVD_MASK (`CMPSEL_POS_RSVD)
    ) u_pos_decode (
        .code (next_pos_code),
        .sel  (next_pos_sel)
    );

    // State registers; reset leaves both fields at 1111
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            comparator1_input_select <= `CMPSEL_REG_RESET;
            sfr_rdata                <= 8'h00;
            sfr_rdata_valid          <= 1'b0;
            neg_sel                  <= 16'h8000;
            pos_sel                  <= 16'h8000;
        end else begin
            comparator1_input_select <= next_comparator1_input_select;
            sfr_rdata                <= next_sfr_rdata;
            sfr_rdata_valid          <= next_sfr_rdata_valid;
            neg_sel                  <= next_neg_sel;
            pos_sel                  <= next_pos_sel;
        end
    end

    // Checks on the register, its read path and the switch decode
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    cmpsel_pkg::cmpsel_code_t neg_code_q;
    cmpsel_pkg::cmpsel_code_t pos_code_q;
    assign neg_code_q = comparator1_input_select[`CMPSEL_NEG_MSB:`CMPSEL_NEG_LSB];
    assign pos_code_q = comparator1_input_select[`CMPSEL_POS_MSB:`CMPSEL_POS_LSB];

    // A write to the register lands exactly one cycle later
    property p_write_lands;
        (sfr_wr && hit) |=> (comparator1_input_select == $past(sfr_wdata));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write did not land");

    // Any other address leaves the register untouched
    property p_miss_keeps;
        !(sfr_wr && hit) |=> $stable(comparator1_input_select);
    endproperty
    a_miss_keeps: assert property (p_miss_keeps) else $error("register changed without write");

    // A read answers next cycle with the pre-access value
    property p_read_answer;
        (sfr_rd && hit) |=> (sfr_rdata_valid && sfr_rdata == $past(comparator1_input_select));
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("bad read answer");

    // Valid only ever follows a hit read
    property p_valid_cause;
        sfr_rdata_valid |-> $past(sfr_rd && hit);
    endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("spurious read valid");

    // After reset the register reads all ones and both top codes are chosen
    property p_reset_value;
        disable iff (1'b0)
        ($past(sys_rst) && !sys_rst) |-> (comparator1_input_select == `CMPSEL_REG_RESET && neg_sel == 16'h8000
                                          && pos_sel == 16'h8000);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad reset state");

    // Negative pins follow the stored code, at most one switch closed
    property p_neg_decode;
        neg_sel == ((16'h0001 << neg_code_q) & ~`CMPSEL_NEG_RSVD);
    endproperty
    a_neg_decode: assert property (p_neg_decode) else $error("negative decode mismatch");

    // Positive pins follow the stored code, P1.6 at 0111 included
    property p_pos_decode;
        pos_sel == ((16'h0001 << pos_code_q) & ~`CMPSEL_POS_RSVD);
    endproperty
    a_pos_decode: assert property (p_pos_decode) else $error("positive pin decode wrong");

    // Internal sources: touch reference on the negative field, half and top codes on the positive field
    property p_internal;
        (neg_code_q == `CMPSEL_CODE_TOUCH |-> neg_sel[12]) and
        (pos_code_q == `CMPSEL_CODE_HALF  |-> pos_sel[13]) and
        (pos_code_q == `CMPSEL_CODE_TOP   |-> pos_sel == 16'h8000);
    endproperty
    a_internal: assert property (p_internal) else $error("internal source decode wrong");

    // Reserved codes 1011 (negative) and 0110 (positive) close no switch yet the stored register still holds them as written
    property p_reserved;
        (sfr_wr && hit && (sfr_wdata[7:4] == 4'hb || sfr_wdata[3:0] == 4'h6))
        |=> ((neg_code_q != 4'hb) || (neg_sel == 16'h0000)) && ((pos_code_q != 4'h6) || (pos_sel == 16'h0000))
            ##1 ($past(sfr_wr && hit) || comparator1_input_select == $past(sfr_wdata, 2));
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code closed a switch");

    // Read data holds between hit reads so software sees a steady byte
    property p_rdata_holds;
        !(sfr_rd && hit) |=> $stable(sfr_rdata);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without read");

    // Valid is a single pulse unless another read follows
    property p_valid_single;
        (sfr_rdata_valid && !(sfr_rd && hit)) |=> !sfr_rdata_valid;
    endproperty
    a_valid_single: assert property (p_valid_single) else $error("read valid stretched");

    // Reset clears the read path as well as the register
    property p_rst_rdata;
        disable iff (1'b0)
        ($past(sys_rst) && !sys_rst) |-> (sfr_rdata == 8'h00 && !sfr_rdata_valid);
    endproperty
    a_rst_rdata: assert property (p_rst_rdata) else $error("read path not cleared by reset");

    // Two closed switches would short two pins together
    property p_neg_onehot;
        $onehot0(neg_sel);
    endproperty
    a_neg_onehot: assert property (p_neg_onehot) else $error("negative switches not one-hot");

    // Same hazard on the positive multiplexer
    property p_pos_onehot;
        $onehot0(pos_sel);
    endproperty
    a_pos_onehot: assert property (p_pos_onehot) else $error("positive switches not one-hot");

    // Negative field internal sources: halved supply, digital supply, ground
    property p_neg_internal;
        (neg_code_q == `CMPSEL_CODE_HALF   |-> neg_sel == 16'h2000) and
        (neg_code_q == `CMPSEL_CODE_SUPPLY |-> neg_sel == 16'h4000) and
        (neg_code_q == `CMPSEL_CODE_TOP    |-> neg_sel == 16'h8000);
    endproperty
    a_neg_internal: assert property (p_neg_internal) else $error("negative internal decode wrong");

    // Positive field internal sources: touch reference and battery
    property p_pos_internal;
        (pos_code_q == `CMPSEL_CODE_TOUCH  |-> pos_sel == 16'h1000) and
        (pos_code_q == `CMPSEL_CODE_SUPPLY |-> pos_sel == 16'h4000);
    endproperty
    a_pos_internal: assert property (p_pos_internal) else $error("positive internal decode wrong");

    // Every reserved negative code leaves the input floating
    property p_neg_rsvd_all;
        (neg_code_q inside {4'h4, 4'h5, 4'hb}) |-> (neg_sel == 16'h0000);
    endproperty
    a_neg_rsvd_all: assert property (p_neg_rsvd_all) else $error("reserved negative code closed a switch");

    // Every reserved positive code leaves the input floating
    property p_pos_rsvd_all;
        (pos_code_q inside {4'h4, 4'h5, 4'h6}) |-> (pos_sel == 16'h0000);
    endproperty
    a_pos_rsvd_all: assert property (p_pos_rsvd_all) else $error("reserved positive code closed a switch");

    // Switches only move on a hit write, never on a stray strobe
    property p_sel_stable;
        !(sfr_wr && hit) |=> ($stable(neg_sel) && $stable(pos_sel));
    endproperty
    a_sel_stable: assert property (p_sel_stable) else $error("switches moved without write");

    // Main scenarios; the bench leaves an idle cycle between accesses
    c_write: cover property (sfr_wr && hit ##[1:3] sfr_rd && hit ##1 sfr_rdata_valid);
    c_reserved_neg: cover property (neg_code_q == 4'h4 && neg_sel == 16'h0000);
    c_ground: cover property (neg_code_q == `CMPSEL_CODE_TOP && !$past(sys_rst));
    c_battery: cover property (pos_code_q == `CMPSEL_CODE_SUPPLY);

endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the comparator1 input select register
// Assumes: Inputs driven on the falling edge, seed 26, sync reset
// Notes:   Expected select lines come from a local decode of each code
`timescale 1ns/1ps
module testbench;
    logic                     core_clk, sys_rst, sfr_wr, sfr_rd, sfr_rdata_valid;
    logic [7:0]               sfr_page, sfr_addr, shadow, d, pg, ad;
    cmpsel_pkg::cmpsel_byte_t sfr_wdata, sfr_rdata, comparator1_input_select;
    cmpsel_pkg::cmpsel_sel_t  neg_sel, pos_sel;
    int                       errors, cmp_count, cycles;

    cmpsel_top cmpsel_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .sfr_page(sfr_page),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_rdata_valid(sfr_rdata_valid),
        .comparator1_input_select(comparator1_input_select), .neg_sel(neg_sel), .pos_sel(pos_sel));

    // Free-running core clock, 50 ns period
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Reserved codes leave the comparator input floating
    function automatic logic [15:0] exp_sel(input logic [3:0] c, input logic neg);
        logic [15:0] rsvd;
        rsvd = neg ? 16'h0830 : 16'h0070;
        exp_sel = rsvd[c] ? 16'h0000 : (16'h0001 << c);
    endfunction

    task automatic wrap_up;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // One strobe cycle; returns after the taking edge has landed
    task automatic access(input logic [7:0] p, input logic [7:0] a, input logic [7:0] wd,
                          input logic w, input logic r);
        @(negedge core_clk);
        sfr_page  = p;
        sfr_addr  = a;
        sfr_wdata = wd;
        sfr_wr    = w;
        sfr_rd    = r;
        @(negedge core_clk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    endtask

    task automatic check_state(input logic [7:0] v);
        chk8(comparator1_input_select, v, "stored value");
        chk16(neg_sel, exp_sel(v[7:4], 1'b1), "negative select");
        chk16(pos_sel, exp_sel(v[3:0], 1'b0), "positive select");
    endtask

    // Valid must pulse only for a hit and last exactly one cycle
    task automatic read_check(input logic [7:0] p, input logic [7:0] a, input logic hit,
                              input logic [7:0] v);
        access(p, a, 8'h00, 1'b0, 1'b1);
        chk8({7'h00, sfr_rdata_valid}, {7'h00, hit}, "read valid");
        if (hit)
            chk8(sfr_rdata, v, "read data");
        @(negedge core_clk);
        chk8({7'h00, sfr_rdata_valid}, 8'h00, "valid width");
    endtask

    // Hang guard, far above the expected run length
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("CHECK FAILED t=%0t timeout", $time);
            wrap_up;
        end
    end

    initial begin
        sys_rst = 1'b1;
        {sfr_page, sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = '0;
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        void'($urandom(26));
        repeat (4) @(negedge core_clk);
        sys_rst = 1'b0;
        check_state(8'hff);
        read_check(8'h00, 8'h9e, 1'b1, 8'hff);
        // Every code in both fields, reserved ones included
        for (int c = 0; c < 16; c++) begin
            d = {c[3:0], 4'hf - c[3:0]};
            access(8'h00, 8'h9e, d, 1'b1, 1'b0);
            check_state(d);
            read_check(8'h00, 8'h9e, 1'b1, d);
        end
        // Neighbouring page and address must not hit
        access(8'h01, 8'h9e, 8'h5a, 1'b1, 1'b0);
        access(8'h00, 8'h9f, 8'h5a, 1'b1, 1'b0);
        check_state(d);
        read_check(8'h01, 8'h9e, 1'b0, d);
        read_check(8'h00, 8'h9f, 1'b0, d);
        // Write and read together: old value read, new one stored
        access(8'h00, 8'h9e, 8'h3c, 1'b1, 1'b1);
        chk8(sfr_rdata, d, "same-cycle read");
        check_state(8'h3c);
        shadow = 8'h3c;
        // Random traffic, mostly hits, some misses
        repeat (40) begin
            d  = 8'($urandom);
            pg = ($urandom_range(3) == 0) ? 8'($urandom_range(2)) : 8'h00;
            ad = ($urandom_range(3) == 0) ? 8'($urandom) : 8'h9e;
            access(pg, ad, d, 1'b1, 1'b0);
            if (pg == 8'h00 && ad == 8'h9e)
                shadow = d;
            check_state(shadow);
        end
        // Reset in mid-run restores all ones
        @(negedge core_clk);
        sys_rst = 1'b1;
        @(negedge core_clk);
        sys_rst = 1'b0;
        check_state(8'hff);
        chk8(sfr_rdata, 8'h00, "read data after reset");
        wrap_up;
    end
endmodule
